// *** rtl/pms_pkg.sv ***
// Purpose: Constants for the pin mode select multiplexer
// Assumes: AHB-Lite register access, 32-bit word per register
// Notes:   Offsets are byte addresses
package pms_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_FLAGDIR = 8'h04;
   localparam logic [7:0] REG_FLAGOUT = 8'h08;
   localparam logic [7:0] REG_FIXFLAG = 8'h0C;
   localparam logic [7:0] REG_INTERRUPT_ENABLE_MASK   = 8'h10;
   localparam logic [7:0] REG_STATUS  = 8'h14;
   localparam logic [7:0] REG_IRQCLR  = 8'h18;
   // Control register fields
   localparam int CTRL_SERALT = 0;
   localparam int CTRL_IRQ2EDGE = 1;
   localparam int CTRL_IRQ0EDGE = 2;
   localparam int CTRL_IRQ1EDGE = 3;
   localparam int CTRL_FOBIT = 4;
   localparam int CTRL_W = 5;
   // Status register fields
   localparam int ST_STRAP = 0;
   localparam int ST_HOST = 4;
   localparam int ST_FLAGS = 5;
   localparam int ST_FI = 13;
   localparam int ST_IRQ = 14;
   // Strap bits
   localparam int STRAP_MODEC = 2;
   localparam int STRAP_MODED = 3;
   // Interrupt vector bits
   localparam int IRQ_EDGE = 0;
   localparam int IRQ_LVL0 = 1;
   localparam int IRQ_LVL1 = 2;
   localparam int IRQ_DUAL = 3;
   localparam int IRQ_SER0 = 4;
   localparam int IRQ_SER1 = 5;
   localparam int IRQ_N = 6;
   // Serial port pin positions
   localparam int SP_CLK = 0;
   localparam int SP_IRQ0 = 1;
   localparam int SP_IRQ1 = 2;
   localparam int SP_FI = 3;
   localparam int SP_FO = 4;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam logic [7:0] FLAGDIR_RST = 8'h00;
   localparam logic [7:0] FLAGOUT_RST = 8'h00;
   localparam logic [2:0] FIXFLAG_RST = 3'h0;
   localparam logic [IRQ_N-1:0] INTERRUPT_ENABLE_MASK_RST = 6'h00;
   // Edges after reset release before the straps are taken
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// *** rtl/pms_pin_mux.sv ***
// Purpose: Pin function multiplexer with reset-time mode strapping
// Assumes: All pin inputs are asynchronous and pass two flip-flops
// Notes:   Active low pins carry an N suffix
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
// Contract
// (RL1) External bus pin functions fixed from reset, never changed later.
// (RL2) Software may reassign second serial port pins at any time.
// (RL3) Shared flag/interrupt pins keep both functions concurrently.
// (RL4) Enabled interrupt fires whether pin driven externally or by own flag.
// (RL5) Dual-sense interrupt on flag 7 selectable edge or level.
// (RL6) Level interrupts on flags 6 and 5 request while held active.
// (RL7) Edge interrupt on flag 4 requests only on active transition.
// (RL8) Mode straps sampled at reset only, ignored afterwards.
// (RL9) After reset strap pins are general flags 0 to 3.
// (RL10) Operating mode taken from latched mode C, fixed while running.
// (RL11) Mode C one selects host port mode, else wide bus mode.
// (RL12) Wide mode: byte engine and full bus; host mode: limited addressing.
// (RL13) Wide mode drives 14-bit address and 24-bit data bus.
// (RL14) Wide mode uses top 8 data lines as byte space address.
// (RL15) Host mode: 16-bit host address/data bus, host drives strobes.
// (RL16) Host mode keeps one address line and 16 upper data lines.
// (RL17) Host acknowledge is open drain, behaviour set by mode D.
// (RL18) Host mode peripherals decode single address line plus selects.
// (RL19) Separate space selects plus read and write strobes driven.
// (RL20) Bus request answered by bus grant, plus grant-hung output.
// (RL21) Control bit turns serial port into interrupts and flags.
// (RL22) Eight programmable flags plus three output-only flags.
// (RL23) Straps latched into mode register after reset, selects derive from it.
module pms_pin_mux (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Core memory side
   input  wire logic [13:0] coreAddr,
   input  wire logic [23:0] coreWdata,
   input  wire logic        coreDataOe,
   input  wire logic [7:0]  coreByteAddrHi,
   input  wire logic [4:0]  coreSpaceSel,
   input  wire logic        coreRd,
   input  wire logic        coreWr,
   input  wire logic        coreHoldOk,
   input  wire logic        coreExtReq,
   output logic      [23:0] coreRdata,
   output logic             hostMode,
   output logic             busGranted,
   // External bus pins
   output logic      [13:0] extAddrOut,
   output logic      [13:0] extAddrOe,
   input  wire logic [23:0] extDataIn,
   output logic      [23:0] extDataOut,
   output logic      [23:0] extDataOe,
   output logic      [4:0]  spaceSelN,
   output logic             rdN,
   output logic             wrN,
   output logic             strobeOe,
   input  wire logic        busRequestInN,
   output logic             busGrantOutN,
   output logic             busGrantHungOutN,
   // Host port pins and core side
   input  wire logic [15:0] hostAdIn,
   output logic      [15:0] hostAdOut,
   output logic             hostAdOe,
   input  wire logic        hostWriteStrobeN,
   input  wire logic        hostReadStrobeN,
   input  wire logic        hostAddrLatch,
   input  wire logic        hostPortSelectN,
   output logic             hostAckOut,
   output logic             hostAckOe,
   input  wire logic [15:0] coreHostRdata,
   input  wire logic        coreHostBusy,
   output logic      [15:0] hostAdToCore,
   output logic      [3:0]  hostStrobesToCore,
   // Flag and interrupt pins
   input  wire logic [7:0]  flagPinIn,
   output logic      [7:0]  flagPinOut,
   output logic      [7:0]  flagPinOe,
   output logic      [2:0]  fixedOutputFlags,
   output logic      [5:0]  irqReq,
   // Second serial port pins and core side
   input  wire logic [4:0]  spPinIn,
   output logic      [4:0]  spPinOut,
   output logic      [4:0]  spPinOe,
   input  wire logic [4:0]  coreSerOut,
   input  wire logic [4:0]  coreSerOe,
   output logic      [4:0]  coreSerIn
);
   typedef struct packed {
      logic [1:0]  settle;
      logic        modeDone;
      logic [3:0]  straps;
      logic [4:0]  ctrl;
      logic [7:0]  flagDir;
      logic [7:0]  flagOut;
      logic [2:0]  fixFlag;
      logic [5:0]  irqMask;
      logic [5:0]  edgeHeld;
      logic [7:0]  flagS1;
      logic [7:0]  flagS2;
      logic [7:0]  flagS3;
      logic [4:0]  spS1;
      logic [4:0]  spS2;
      logic [4:0]  spS3;
      logic        brS1;
      logic        brS2;
      logic [3:0]  hsS1;
      logic [3:0]  hsS2;
      logic [15:0] hadS1;
      logic [15:0] hadS2;
      logic [23:0] datS1;
      logic [23:0] datS2;
      logic        granted;
      logic        wrPend;
      logic [7:0]  wrAddr;
      logic [31:0] rdata;
      logic        readyOut;
      logic [13:0] addrOut;
      logic [13:0] addrOe;
      logic [23:0] dataOut;
      logic [23:0] dataOe;
      logic [4:0]  selN;
      logic        rdN;
      logic        wrN;
      logic        strOe;
      logic        grantN;
      logic        hungN;
      logic [15:0] hostOut;
      logic        hostOe;
      logic        ackOe;
      logic [15:0] hostToCore;
      logic [3:0]  hostStb;
      logic [7:0]  flagPOut;
      logic [7:0]  flagPOe;
      logic [4:0]  spOut;
      logic [4:0]  spOe;
      logic [5:0]  irq;
   } pms_state_s;

   pms_state_s state;
   pms_state_s next_state;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic        isHost;
      logic        alt;
      logic        byteSel;
      logic        addrPhase;
      logic [5:0]  isEdge;
      logic [5:0]  pinLow;
      logic [5:0]  prevLow;
      logic [5:0]  clr;
      logic [31:0] status;
      logic [31:0] rd;
      next_state = state;
      isHost = state.straps[pms_pkg::STRAP_MODEC];                      // [RL11]
      alt = state.ctrl[pms_pkg::CTRL_SERALT];
      byteSel = coreSpaceSel[3];
      addrPhase = hsel & htrans[1] & hready;
      clr = 6'h00;

      // Input synchronisers
      next_state.flagS1 = flagPinIn;
      next_state.flagS2 = state.flagS1;
      next_state.flagS3 = state.flagS2;
      next_state.spS1 = spPinIn;
      next_state.spS2 = state.spS1;
      next_state.spS3 = state.spS2;
      next_state.brS1 = busRequestInN;
      next_state.brS2 = state.brS1;
      next_state.hsS1 = {hostPortSelectN, hostAddrLatch, hostReadStrobeN, hostWriteStrobeN};
      next_state.hsS2 = state.hsS1;
      next_state.hadS1 = hostAdIn;
      next_state.hadS2 = state.hadS1;
      next_state.datS1 = extDataIn;
      next_state.datS2 = state.datS1;

      // Strap capture once, after synchronisers hold post-reset pin levels
      if (!state.modeDone) begin
         if (state.settle == pms_pkg::STRAP_SETTLE) begin
            next_state.modeDone = 1'b1;                                 // [RL8] [RL23]
            next_state.straps = state.flagS2[3:0];                      // [RL1] [RL10]
         end else begin
            next_state.settle = state.settle + 2'h1;
         end
      end

      // Register writes in the data phase
      if (state.wrPend) begin
         case (state.wrAddr)
            pms_pkg::REG_CTRL:    next_state.ctrl = hwdata[pms_pkg::CTRL_W-1:0]; // [RL2] [RL21]
            pms_pkg::REG_FLAGDIR: next_state.flagDir = hwdata[7:0];     // [RL22]
            pms_pkg::REG_FLAGOUT: next_state.flagOut = hwdata[7:0];
            pms_pkg::REG_FIXFLAG: next_state.fixFlag = hwdata[2:0];     // [RL22]
            pms_pkg::REG_INTERRUPT_ENABLE_MASK:   next_state.irqMask = hwdata[5:0];
            pms_pkg::REG_IRQCLR:  clr = hwdata[5:0];
            default: ;
         endcase
      end

      // Interrupt sensing on the pin wire, own drive included
      isEdge = {state.ctrl[pms_pkg::CTRL_IRQ1EDGE], state.ctrl[pms_pkg::CTRL_IRQ0EDGE],
                state.ctrl[pms_pkg::CTRL_IRQ2EDGE], 1'b0, 1'b0, 1'b1};    // [RL5] [RL6] [RL7]
      pinLow = {~state.spS2[pms_pkg::SP_IRQ1] & alt, ~state.spS2[pms_pkg::SP_IRQ0] & alt,
                ~state.flagS2[7:4]};                                     // [RL3] [RL4]
      prevLow = {~state.spS3[pms_pkg::SP_IRQ1] & alt, ~state.spS3[pms_pkg::SP_IRQ0] & alt,
                 ~state.flagS3[7:4]};
      // Edge capture wins over a same-cycle clear
      next_state.edgeHeld = (state.edgeHeld & ~clr) | (pinLow & ~prevLow & isEdge); // [RL7]
      next_state.irq = state.irqMask & ((isEdge & state.edgeHeld)
                                        | (~isEdge & pinLow));           // [RL4] [RL6]

      // Status and read data, captured in the address phase
      status = 32'h0000_0000;
      status[pms_pkg::ST_STRAP +: 4] = state.straps;
      status[pms_pkg::ST_HOST] = isHost;
      status[pms_pkg::ST_FLAGS +: 8] = state.flagS2;                    // [RL9]
      status[pms_pkg::ST_FI] = state.spS2[pms_pkg::SP_FI];              // [RL21]
      status[pms_pkg::ST_IRQ +: 6] = state.irq;
      case (haddr[7:0])
         pms_pkg::REG_CTRL:    rd = {27'h000_0000, state.ctrl};
         pms_pkg::REG_FLAGDIR: rd = {24'h00_0000, state.flagDir};
         pms_pkg::REG_FLAGOUT: rd = {24'h00_0000, state.flagOut};
         pms_pkg::REG_FIXFLAG: rd = {29'h0000_0000, state.fixFlag};
         pms_pkg::REG_INTERRUPT_ENABLE_MASK:   rd = {26'h000_0000, state.irqMask};
         pms_pkg::REG_STATUS:  rd = status;
         default:              rd = 32'h0000_0000;
      endcase
      if (haddr[31:8] != 24'h00_0000) begin
         rd = 32'h0000_0000;
      end
      next_state.wrPend = addrPhase & hwrite;
      next_state.wrAddr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFC;
      next_state.rdata = (addrPhase & ~hwrite) ? rd : 32'h0000_0000;
      next_state.readyOut = 1'b1;

      // Bus arbitration
      if (state.brS2) begin
         next_state.granted = 1'b0;
      end else if (coreHoldOk) begin
         next_state.granted = 1'b1;
      end
      next_state.grantN = ~next_state.granted;                          // [RL20]
      next_state.hungN = ~(state.granted & coreExtReq);                 // [RL20]

      // External memory bus, mode fixed at strap time
      next_state.addrOut = coreAddr;
      next_state.dataOut = coreWdata;
      if (!isHost && byteSel) begin
         next_state.dataOut[23:16] = coreByteAddrHi;                    // [RL14]
      end
      if (!state.modeDone || state.granted) begin
         next_state.addrOe = 14'h0000;
         next_state.dataOe = 24'h00_0000;
      end else if (isHost) begin
         next_state.addrOe = 14'h0001;                                  // [RL16] [RL12]
         next_state.dataOe = {{16{coreDataOe}}, 8'h00};                 // [RL16]
      end else begin
         next_state.addrOe = 14'h3FFF;                                  // [RL13] [RL12]
         next_state.dataOe = {{8{coreDataOe | byteSel}}, {16{coreDataOe}}}; // [RL13] [RL14]
      end
      next_state.selN = ~coreSpaceSel;                                  // [RL19]
      next_state.rdN = ~coreRd;                                         // [RL19]
      next_state.wrN = ~coreWr;                                         // [RL19]
      next_state.strOe = state.modeDone & ~state.granted;

      // Host port, active only in host mode
      if (isHost && state.modeDone) begin
         next_state.hostStb = state.hsS2;                               // [RL15]
         next_state.hostToCore = state.hadS2;                           // [RL15]
         next_state.hostOe = ~state.hsS2[3] & ~state.hsS2[1];           // [RL15]
         next_state.ackOe = state.straps[pms_pkg::STRAP_MODED]
                            ? (~coreHostBusy & ~state.hsS2[3])
                            : coreHostBusy;                             // [RL17]
      end else begin
         next_state.hostStb = 4'hB;
         next_state.hostToCore = 16'h0000;
         next_state.hostOe = 1'b0;
         next_state.ackOe = 1'b0;
      end
      next_state.hostOut = coreHostRdata;

      // Programmable flags, strap pins released only after capture
      next_state.flagPOut = state.flagOut;                              // [RL9] [RL22]
      next_state.flagPOe = state.modeDone ? state.flagDir : 8'h00;      // [RL9] [RL3]

      // Second serial port, reconfigurable at run time
      if (alt) begin
         next_state.spOut = {state.ctrl[pms_pkg::CTRL_FOBIT], 3'h0,
                             coreSerOut[pms_pkg::SP_CLK]};              // [RL21]
         next_state.spOe = {1'b1, 3'h0, coreSerOe[pms_pkg::SP_CLK]};    // [RL21] [RL2]
      end else begin
         next_state.spOut = coreSerOut;
         next_state.spOe = coreSerOe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
         state.ctrl <= pms_pkg::CTRL_RST;
         state.flagDir <= pms_pkg::FLAGDIR_RST;
         state.flagOut <= pms_pkg::FLAGOUT_RST;
         state.fixFlag <= pms_pkg::FIXFLAG_RST;
         state.irqMask <= pms_pkg::INTERRUPT_ENABLE_MASK_RST;
         state.flagS1 <= 8'hFF;
         state.flagS2 <= 8'hFF;
         state.flagS3 <= 8'hFF;
         state.spS1 <= 5'h1F;
         state.spS2 <= 5'h1F;
         state.spS3 <= 5'h1F;
         state.brS1 <= 1'b1;
         state.brS2 <= 1'b1;
         state.hsS1 <= 4'hB;
         state.hsS2 <= 4'hB;
         state.selN <= 5'h1F;
         state.rdN <= 1'b1;
         state.wrN <= 1'b1;
         state.grantN <= 1'b1;
         state.hungN <= 1'b1;
         state.hostStb <= 4'hB;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata = state.rdata;
   assign hreadyout = state.readyOut;
   assign hresp = 1'b0;
   assign coreRdata = state.datS2;
   assign hostMode = state.straps[pms_pkg::STRAP_MODEC];
   assign busGranted = state.granted;
   assign extAddrOut = state.addrOut;
   assign extAddrOe = state.addrOe;
   assign extDataOut = state.dataOut;
   assign extDataOe = state.dataOe;
   assign spaceSelN = state.selN;
   assign rdN = state.rdN;
   assign wrN = state.wrN;
   assign strobeOe = state.strOe;
   assign busGrantOutN = state.grantN;
   assign busGrantHungOutN = state.hungN;
   assign hostAdOut = state.hostOut;
   assign hostAdOe = state.hostOe;
   assign hostAckOut = 1'b0;
   assign hostAckOe = state.ackOe;
   assign hostAdToCore = state.hostToCore;
   assign hostStrobesToCore = state.hostStb;
   assign flagPinOut = state.flagPOut;
   assign flagPinOe = state.flagPOe;
   assign fixedOutputFlags = state.fixFlag;
   assign irqReq = state.irq;
   assign spPinOut = state.spOut;
   assign spPinOe = state.spOe;
   assign coreSerIn = state.spS2;
endmodule

// *** sim/pms_pin_mux_properties.sv ***
// Purpose: Port-level assertions for the pin mux
// Assumes: Single clock domain
// Notes:   Bound to every pms_pin_mux instance
`timescale 1ns/1ps
module pms_pin_mux_properties (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Watched ports
   input  wire logic        hostMode,
   input  wire logic        busGranted,
   input  wire logic        coreHoldOk,
   input  wire logic        busRequestInN,
   input  wire logic        busGrantOutN,
   input  wire logic        strobeOe,
   input  wire logic [13:0] extAddrOe,
   input  wire logic [23:0] extDataOe,
   input  wire logic        hostAdOe,
   input  wire logic        hostAckOut
);
   logic [2:0] relCnt;

   // Cycles since reset release, saturating
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         relCnt <= 3'h0;
      end else if (relCnt != 3'h7) begin
         relCnt <= relCnt + 3'h1;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   mode_frozen_a: assert property (relCnt == 3'h7 |-> $stable(hostMode))
      else $error("mode changed");
   ack_open_drain_a: assert property (hostAckOut == 1'b0)
      else $error("ack driven high");
   host_pins_wide_a: assert property (!hostMode |-> !hostAdOe)
      else $error("host bus driven in wide mode");
   host_addr_lines_a: assert property (hostMode |-> extAddrOe[13:1] == 13'h0000
      && extDataOe[7:0] == 8'h00)
      else $error("lost bus line driven");
   grant_pin_a: assert property (busGrantOutN == !busGranted)
      else $error("grant pin mismatch");
   grant_cause_a: assert property ($rose(busGranted) |-> $past(busRequestInN, 2) == 1'b0)
      else $error("grant without a request");
   grant_hold_a: assert property ($rose(busGranted) |-> $past(coreHoldOk))
      else $error("grant without hold");
   grant_release_a: assert property (busGranted ##1 busGranted |->
      !strobeOe && extAddrOe == 14'h0000)
      else $error("bus driven while granted");
endmodule

bind pms_pin_mux pms_pin_mux_properties u_pms_pin_mux_properties (.*);

// *** sim/pms_far_side.sv ***
// Purpose: Far side of the pins: memory, bus master and host
// Assumes: Bench commands are levels
// Notes:   Released data lines toggle every cycle
`timescale 1ns/1ps
module pms_far_side (
   // Clock and bench commands
   input  wire logic        ref_clk,
   input  wire logic        wantBus,
   input  wire logic        hostRead,
   // Memory side
   input  wire logic [13:0] extAddrOut,
   input  wire logic [4:0]  spaceSelN,
   input  wire logic        rdN,
   input  wire logic        strobeOe,
   output logic      [23:0] extDataIn,
   // Bus master and host
   output logic             busRequestInN,
   output logic      [15:0] hostAdIn,
   output logic             hostWriteStrobeN,
   output logic             hostReadStrobeN,
   output logic             hostAddrLatch,
   output logic             hostPortSelectN
);
   initial begin
      extDataIn = 24'hA5_5A5A;
      hostAdIn = 16'h3C3C;
      {busRequestInN, hostWriteStrobeN, hostReadStrobeN, hostAddrLatch, hostPortSelectN} = 5'h1D;
   end

   always @(posedge ref_clk) begin
      // Selected memory answers a read with its address
      if (strobeOe && !rdN && !(&spaceSelN)) begin
         extDataIn <= {10'h000, extAddrOut};
      end else begin
         extDataIn <= ~extDataIn;
      end
      hostAdIn <= ~hostAdIn;
      busRequestInN <= !wantBus;
      hostPortSelectN <= !hostRead;
      hostReadStrobeN <= !hostRead;
   end
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the pin mux
// Assumes: Straps on flag pins 3:0
// Notes:   Register model is a masked integer array
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk, rst, hsel, hwrite, holdOk, busy, wantBus, hostRead;
   logic        hreadyout, hostMode, busGranted, rdN, strobeOe, busGrantOutN, hostAdOe;
   logic        hostAckOe, busRequestInN, hWrN, hRdN, hAl, hSelN, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [79:0] rnd;
   logic [4:0]  spaceSel, spaceSelN, spIn, spPin, spPinOut, spPinOe;
   logic [13:0] extAddrOut;
   logic [23:0] extDataIn;
   logic [15:0] hostAdIn;
   logic [7:0]  flagExt, flagPin, flagPinOut, flagPinOe;
   logic [2:0]  fixedOutputFlags;
   logic [5:0]  irqReq;
   int          errorCnt, samplesChecked, cyc, seed;
   int          shadow [5];
   int          mask [5] = '{32'h0000_001F, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_0007,
                             32'h0000_003F};

   assign flagPin = (flagPinOe & flagPinOut) | (~flagPinOe & flagExt);
   assign spPin = (spPinOe & spPinOut) | (~spPinOe & spIn);

   pms_pin_mux u_pms_pin_mux (
      .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .coreAddr(rnd[13:0]), .coreWdata(rnd[37:14]), .coreDataOe(rnd[38]),
      .coreByteAddrHi(rnd[46:39]), .coreSpaceSel(spaceSel), .coreRd(rnd[47]),
      .coreWr(rnd[48]), .coreHoldOk(holdOk), .coreExtReq(rnd[49]), .coreRdata(),
      .hostMode, .busGranted, .extAddrOut, .extAddrOe(), .extDataIn, .extDataOut(),
      .extDataOe(), .spaceSelN, .rdN, .wrN(), .strobeOe, .busRequestInN, .busGrantOutN,
      .busGrantHungOutN(), .hostAdIn, .hostAdOut(), .hostAdOe, .hostWriteStrobeN(hWrN),
      .hostReadStrobeN(hRdN), .hostAddrLatch(hAl), .hostPortSelectN(hSelN),
      .hostAckOut(), .hostAckOe, .coreHostRdata(rnd[65:50]), .coreHostBusy(busy),
      .hostAdToCore(), .hostStrobesToCore(), .flagPinIn(flagPin), .flagPinOut,
      .flagPinOe, .fixedOutputFlags, .irqReq, .spPinIn(spPin), .spPinOut, .spPinOe,
      .coreSerOut(rnd[70:66]), .coreSerOe(rnd[75:71]), .coreSerIn()
   );

   pms_far_side u_pms_far_side (
      .ref_clk, .wantBus, .hostRead, .extAddrOut, .spaceSelN, .rdN, .strobeOe,
      .extDataIn, .busRequestInN, .hostAdIn, .hostWriteStrobeN(hWrN),
      .hostReadStrobeN(hRdN), .hostAddrLatch(hAl), .hostPortSelectN(hSelN)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Random core traffic and a hang limit
   always @(posedge ref_clk) begin
      rnd <= 80'({$random(seed), $random(seed), $random(seed)});
      spaceSel <= 5'h01 << ($unsigned($random(seed)) % 5);
      cyc++;
      if (cyc == 20000) begin
         errorCnt++;
         closeOut();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chkBit(input logic seen, input logic exp);
      chk(32'(seen), 32'(exp));
   endtask

   task automatic ahbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      chkBit(hresp, 1'b0);
   endtask

   task automatic regWr(input logic [7:0] a, input logic [31:0] d);
      ahbXfer(1'b1, a, d, v);
      if (a < 8'h14) begin
         shadow[a >> 2] = d & mask[a >> 2];
      end
   endtask

   task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
      ahbXfer(1'b0, a, 32'h0000_0000, v);
      chk(v, exp);
   endtask

   task automatic doReset(input logic [3:0] s);
      rst <= 1'b1;
      flagExt <= {4'hF, s};
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      shadow = '{0, 0, 0, 0, 0};
      repeat (8) @(posedge ref_clk);
      flagExt[3:0] <= ~s;
      repeat (8) @(posedge ref_clk);
      chkBit(hostMode, s[2]);
      ahbXfer(1'b0, 8'h14, 32'h0000_0000, v);
      chk(v & 32'h000F_DFFF, {19'h0_0000, 4'hF, ~s, s[2], s});
      $display("test reset strap %h done", s);
   endtask

   task automatic irqTry(input int pin, input int bitn, input logic expLow, input logic expAfter);
      flagExt[pin] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chkBit(irqReq[bitn], expLow);
      flagExt[pin] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chkBit(irqReq[bitn], expAfter);
   endtask

   task automatic closeOut;
      $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h7bb8;
      rst = 1'b1;
      {hsel, hwrite, holdOk, busy, wantBus, hostRead} = 6'h08;
      htrans = 2'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      flagExt = 8'hFF;
      spIn = 5'h1F;
      doReset(4'h3);
      for (int i = 0; i < 5; i++) begin
         regRd(8'(4 * i), 32'h0000_0000);
         regWr(8'(4 * i), 32'($random(seed)));
         regRd(8'(4 * i), shadow[i]);
      end
      regRd(8'h1C, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      chk(32'(flagPinOe), shadow[1]);
      chk(32'(flagPinOut), shadow[2]);
      chk(32'(fixedOutputFlags), shadow[3]);
      regWr(8'h04, 32'h0000_0000);
      regWr(8'h00, 32'h0000_0000);
      regWr(8'h10, 32'h0000_003F);
      regWr(8'h18, 32'h0000_003F);
      $display("test registers done");
      irqTry(5, 1, 1'b1, 1'b0);
      irqTry(6, 2, 1'b1, 1'b0);
      irqTry(4, 0, 1'b1, 1'b1);
      regWr(8'h18, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      chkBit(irqReq[0], 1'b0);
      irqTry(7, 3, 1'b1, 1'b0);
      regWr(8'h00, 32'h0000_0002);
      irqTry(7, 3, 1'b1, 1'b1);
      regWr(8'h18, 32'h0000_0008);
      regWr(8'h08, 32'h0000_0000);
      regWr(8'h04, 32'h0000_0040);
      repeat (6) @(posedge ref_clk);
      chkBit(irqReq[2], 1'b1);
      regWr(8'h04, 32'h0000_0000);
      regWr(8'h10, 32'h0000_0000);
      irqTry(5, 1, 1'b0, 1'b0);
      $display("test interrupts done");
      regWr(8'h10, 32'h0000_0010);
      regWr(8'h00, 32'h0000_0011);
      spIn[1] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chkBit(irqReq[4], 1'b1);
      chk(32'({spPinOe[4], spPinOut[4], spPinOe[3:1]}), 32'h0000_0018);
      spIn[1] <= 1'b1;
      regWr(8'h00, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      chkBit(spPinOut[4], 1'b0);
      $display("test serial alternate done");
      holdOk <= 1'b1;
      wantBus <= 1'b1;
      for (int n = 0; n < 20 && busGrantOutN !== 1'b0; n++) @(posedge ref_clk);
      chkBit(busGranted, 1'b1);
      wantBus <= 1'b0;
      for (int n = 0; n < 20 && busGrantOutN !== 1'b1; n++) @(posedge ref_clk);
      chkBit(busGranted, 1'b0);
      $display("test bus grant done");
      doReset(4'hC);
      hostRead <= 1'b1;
      busy <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chkBit(hostAdOe, 1'b1);
      chkBit(hostAckOe, 1'b1);
      busy <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chkBit(hostAckOe, 1'b0);
      hostRead <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chkBit(hostAdOe, 1'b0);
      $display("test host port done");
      closeOut();
   end
endmodule
